// ### rtl/lcai_pkg.sv
package lcai_pkg;
  // ---------------------------------------------------------------
  // register map (word addresses on the plain port)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_STATUS   = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h2;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
  localparam logic [3:0] ADDR_CMD      = 4'h4;

  // ctrl fields
  localparam int CTRL_CONFIGURED  = 0;
  localparam int CTRL_SLOT0_EN    = 1;
  localparam int CTRL_SLOT1_EN    = 2;
  localparam int CTRL_AUTO_REL    = 3;
  localparam int CTRL_TEST_RUN    = 4;
  localparam int CTRL_ALARM_DIS   = 5;
  localparam logic [7:0] CTRL_RESET = 8'h08;

  // cmd fields (write-one pulses)
  localparam int CMD_ALARM_REL    = 0;

  // status / irq fields
  localparam int ST_CARD_LAMP     = 0;
  localparam int ST_NEAR_LAMP     = 1;
  localparam int ST_FAR_LAMP      = 2;
  localparam int ST_SVC_LAMP      = 3;
  localparam int ST_RED_NOW       = 4;
  localparam int ST_ST_DONE       = 5;
  localparam int ST_ST_FAIL       = 6;
  localparam int ST_ACTIVE        = 7;
  localparam int IRQ_RED_SET      = 0;
  localparam int IRQ_RED_CLR      = 1;
  localparam int IRQ_FAR_SET      = 2;
  localparam int IRQ_ST_DONE      = 3;
  localparam int NUM_IRQ          = 4;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam longint CLK_HZ        = 10_000_000;
  localparam longint FLASH_HALF_MS = 250;
  localparam longint FLASH_HALF_CYC = (CLK_HZ * FLASH_HALF_MS) / 1000;
  localparam int     FLASH_COUNT   = 3;

  typedef enum logic [2:0] {
    LCAI_ST_TESTING,
    LCAI_ST_FLASH_OFF,
    LCAI_ST_FLASH_ON,
    LCAI_ST_READY,
    LCAI_ST_FAILED
  } lcai_card_state_t;
endpackage : lcai_pkg

// ### rtl/lcai_alarm_latch.sv
`timescale 1ns/1ps
module lcai_alarm_latch
  import lcai_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic red_now,
  input  wire logic auto_release,
  input  wire logic release_cmd,
  output logic      lamp_q
);
  // ---------------------------------------------------------------
  // near-end lamp latch
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      lamp_q <= 1'b0;
    end else if (red_now) begin
      lamp_q <= 1'b1;
    end else if (auto_release || release_cmd) begin
      lamp_q <= 1'b0;
    end
  end

  latch_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
    lamp_q && !red_now && !auto_release && !release_cmd |=> lamp_q)
    else $error("near lamp dropped without release");
  latch_auto_a: assert property (@(posedge clock) disable iff (!rst_b)
    !red_now && auto_release |=> !lamp_q)
    else $error("near lamp not auto released");
endmodule : lcai_alarm_latch

// ### rtl/lcai_ctrl.sv
`timescale 1ns/1ps
module lcai_ctrl
  import lcai_pkg::*;
#(
  // flash half period in clocks; a bench may shorten it
  parameter longint FLASH_HALF = FLASH_HALF_CYC
) (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       selftest_done,
  input  wire logic       selftest_pass,
  input  wire logic       rx_loss_of_signal,
  input  wire logic       rx_bit_err_exceeded,
  input  wire logic       rx_slip_exceeded,
  input  wire logic       rx_yellow_alarm,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata_q,
  output logic            card_state_lamp_q,
  output logic            near_end_alarm_lamp_q,
  output logic            far_end_alarm_lamp_q,
  output logic            service_mode_lamp_q,
  output logic            tx_yellow_alarm_q,
  output logic            irq_q
);
  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
    end else begin
      sync1_q <= {selftest_done, selftest_pass, rx_loss_of_signal,
                  rx_bit_err_exceeded, rx_slip_exceeded, rx_yellow_alarm};
      sync2_q <= sync1_q;
    end
  end
  logic st_done;
  logic st_pass;
  logic red_now;
  logic yel_now;
  assign st_done = sync2_q[5];
  assign st_pass = sync2_q[4];
  assign red_now = sync2_q[3] | sync2_q[2] | sync2_q[1];
  assign yel_now = sync2_q[0];

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]         ctrl_q;
  logic [NUM_IRQ-1:0] irq_stat_q;
  logic [NUM_IRQ-1:0] irq_mask_q;
  logic               release_cmd;
  logic [NUM_IRQ-1:0] irq_event;
  logic [7:0]         status_vec;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctrl_q <= CTRL_RESET;
    end else if (reg_wr && reg_addr == ADDR_CTRL) begin
      ctrl_q <= reg_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      irq_mask_q <= '0;
    end else if (reg_wr && reg_addr == ADDR_IRQ_MASK) begin
      irq_mask_q <= reg_wdata[NUM_IRQ-1:0];
    end
  end

  assign release_cmd = reg_wr && reg_addr == ADDR_CMD && reg_wdata[CMD_ALARM_REL];

  // sticky status: set beats write-one clear
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IRQ; gi++) begin : g_irq
      always_ff @(posedge clock) begin
        if (!rst_b) begin
          irq_stat_q[gi] <= 1'b0;
        end else if (irq_event[gi]) begin
          irq_stat_q[gi] <= 1'b1;
        end else if (reg_wr && reg_addr == ADDR_IRQ_STAT && reg_wdata[gi]) begin
          irq_stat_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ---------------------------------------------------------------
  // self-test sequencing and card lamp
  // ---------------------------------------------------------------
  lcai_card_state_t state_q;
  logic [23:0]      flash_cnt_q;
  logic [1:0]       flashes_q;
  logic             any_slot_en;
  logic             active;
  logic             st_done_evt;

  assign any_slot_en = ctrl_q[CTRL_SLOT0_EN] | ctrl_q[CTRL_SLOT1_EN];
  assign active      = (state_q == LCAI_ST_READY) && ctrl_q[CTRL_CONFIGURED]
                       && any_slot_en;
  assign st_done_evt = (state_q == LCAI_ST_TESTING) && st_done;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_q     <= LCAI_ST_TESTING;
      flash_cnt_q <= 24'h000000;
      flashes_q   <= 2'h0;
    end else begin
      unique case (state_q)
        LCAI_ST_TESTING: begin
          if (st_done) begin
            flash_cnt_q <= 24'h000000;
            flashes_q   <= 2'h0;
            state_q     <= st_pass ? LCAI_ST_FLASH_OFF : LCAI_ST_FAILED;
          end
        end
        LCAI_ST_FLASH_OFF: begin
          if (flash_cnt_q == 24'(FLASH_HALF - 1)) begin
            flash_cnt_q <= 24'h000000;
            state_q     <= LCAI_ST_FLASH_ON;
          end else begin
            flash_cnt_q <= flash_cnt_q + 24'h000001;
          end
        end
        LCAI_ST_FLASH_ON: begin
          if (flash_cnt_q == 24'(FLASH_HALF - 1)) begin
            flash_cnt_q <= 24'h000000;
            if (flashes_q == 2'(FLASH_COUNT - 1)) begin
              state_q <= LCAI_ST_READY;
            end else begin
              flashes_q <= flashes_q + 2'h1;
              state_q   <= LCAI_ST_FLASH_OFF;
            end
          end else begin
            flash_cnt_q <= flash_cnt_q + 24'h000001;
          end
        end
        LCAI_ST_READY: begin
        end
        LCAI_ST_FAILED: begin
        end
        default: state_q <= LCAI_ST_TESTING;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      card_state_lamp_q <= 1'b1;
    end else begin
      card_state_lamp_q <= (state_q != LCAI_ST_FLASH_OFF) && !active;
    end
  end

  // ---------------------------------------------------------------
  // alarms and service lamp
  // ---------------------------------------------------------------
  lcai_alarm_latch u_near (
    .clock        (clock),
    .rst_b        (rst_b),
    .red_now      (red_now),
    .auto_release (ctrl_q[CTRL_AUTO_REL]),
    .release_cmd  (release_cmd),
    .lamp_q       (near_end_alarm_lamp_q)
  );

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      tx_yellow_alarm_q    <= 1'b0;
      far_end_alarm_lamp_q <= 1'b0;
      service_mode_lamp_q  <= 1'b0;
    end else begin
      tx_yellow_alarm_q    <= red_now;
      far_end_alarm_lamp_q <= yel_now;
      service_mode_lamp_q  <= ctrl_q[CTRL_TEST_RUN] | ctrl_q[CTRL_ALARM_DIS];
    end
  end

  logic red_prev_q;
  logic yel_prev_q;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      red_prev_q <= 1'b0;
      yel_prev_q <= 1'b0;
    end else begin
      red_prev_q <= red_now;
      yel_prev_q <= yel_now;
    end
  end

  assign irq_event[IRQ_RED_SET] = red_now & ~red_prev_q;
  assign irq_event[IRQ_RED_CLR] = ~red_now & red_prev_q;
  assign irq_event[IRQ_FAR_SET] = yel_now & ~yel_prev_q;
  assign irq_event[IRQ_ST_DONE] = st_done_evt;

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always_comb begin
    status_vec               = 8'h00;
    status_vec[ST_CARD_LAMP] = card_state_lamp_q;
    status_vec[ST_NEAR_LAMP] = near_end_alarm_lamp_q;
    status_vec[ST_FAR_LAMP]  = far_end_alarm_lamp_q;
    status_vec[ST_SVC_LAMP]  = service_mode_lamp_q;
    status_vec[ST_RED_NOW]   = red_now;
    status_vec[ST_ST_DONE]   = state_q == LCAI_ST_READY;
    status_vec[ST_ST_FAIL]   = state_q == LCAI_ST_FAILED;
    status_vec[ST_ACTIVE]    = active;
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CTRL:     reg_rdata_q <= ctrl_q;
        ADDR_STATUS:   reg_rdata_q <= status_vec;
        ADDR_IRQ_STAT: reg_rdata_q <= {4'h0, irq_stat_q};
        ADDR_IRQ_MASK: reg_rdata_q <= {4'h0, irq_mask_q};
        default:       reg_rdata_q <= 8'h00;
      endcase
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  card_dark_a: assert property (@(posedge clock) disable iff (!rst_b)
    active |=> !card_state_lamp_q)
    else $error("card lamp lit while active");
  card_fail_a: assert property (@(posedge clock) disable iff (!rst_b)
    state_q == LCAI_ST_FAILED |=> card_state_lamp_q)
    else $error("card lamp dark after failed self-test");
  slot_one_a: assert property (@(posedge clock) disable iff (!rst_b)
    state_q == LCAI_ST_READY && ctrl_q[CTRL_CONFIGURED] && ctrl_q[CTRL_SLOT1_EN]
    |=> !card_state_lamp_q)
    else $error("single slot enable left lamp lit");
  slot_none_a: assert property (@(posedge clock) disable iff (!rst_b)
    state_q == LCAI_ST_READY && !any_slot_en
    |=> card_state_lamp_q)
    else $error("card lamp dark with both slots off");
  near_red_a: assert property (@(posedge clock) disable iff (!rst_b)
    red_now |=> near_end_alarm_lamp_q)
    else $error("near lamp dark during red alarm");
  red_tx_a: assert property (@(posedge clock) disable iff (!rst_b)
    sync2_q[3] |=> tx_yellow_alarm_q)
    else $error("no far-end yellow on signal loss");
  far_lamp_a: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(yel_now) |=> far_end_alarm_lamp_q)
    else $error("far lamp missed yellow");
  svc_lamp_a: assert property (@(posedge clock) disable iff (!rst_b)
    !ctrl_q[CTRL_TEST_RUN] && !ctrl_q[CTRL_ALARM_DIS] |=> !service_mode_lamp_q)
    else $error("service lamp stuck");
  flash_len_a: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(state_q == LCAI_ST_FLASH_OFF) |=> (state_q == LCAI_ST_FLASH_OFF)[*8])
    else $error("flash too short");
  reset_lamps_a: assert property (@(posedge clock)
    !rst_b |=> card_state_lamp_q && !near_end_alarm_lamp_q && !service_mode_lamp_q)
    else $error("reset lamp state wrong");

  flash_c: cover property (@(posedge clock) state_q == LCAI_ST_READY);
  fail_c:  cover property (@(posedge clock) state_q == LCAI_ST_FAILED);
  latch_c: cover property (@(posedge clock)
    near_end_alarm_lamp_q && !red_now && !ctrl_q[CTRL_AUTO_REL]);
  irq_c:   cover property (@(posedge clock) irq_q);
  active_c: cover property (@(posedge clock) active);
endmodule : lcai_ctrl

// ### dv/lcai_far_side.sv
`timescale 1ns/1ps
module lcai_far_side (
  input  wire logic       clock,
  input  wire logic [2:0] cause,
  input  wire logic       far_end_alarm_lamp,
  input  wire logic       fin,
  input  wire logic       ok,
  output logic            los_q,
  output logic            ber_q,
  output logic            slip_q,
  output logic            yel_q,
  output logic            done_q,
  output logic            pass_q
);
  // ---------------------------------------------------------------
  // receive alarm detector and self-test reporter
  // ---------------------------------------------------------------
  initial begin
    {slip_q, ber_q, los_q, yel_q, done_q, pass_q} = 6'h00;
  end

  always @(posedge clock) begin
    {slip_q, ber_q, los_q} <= cause;
    yel_q                  <= far_end_alarm_lamp;
    done_q                 <= fin;
    // result means nothing without done, so keep it moving
    pass_q                 <= fin ? ok : ~pass_q;
  end
endmodule : lcai_far_side

// ### dv/tb_line_card_alarm_indicator_ctrl.sv
`timescale 1ns/1ps
module tb_line_card_alarm_indicator_ctrl;
  import lcai_pkg::*;
  logic       clock = 1'b0;
  logic       rst_b = 1'b0;
  logic [2:0] cause = 3'h0;
  logic       far_end_alarm_lamp   = 1'b0;
  logic       fin   = 1'b0;
  logic       ok    = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] rdata;
  logic       los, ber, slip, ryel, done, pass;
  logic       card, near, far, svc, txy, irq;
  int         bad_count = 0;
  int         tests_run = 0;
  localparam int FLASH_SIM = 40;

  always #50 clock = ~clock;

  lcai_far_side far_u (.clock(clock), .cause(cause), .far_end_alarm_lamp(far_end_alarm_lamp), .fin(fin), .ok(ok),
    .los_q(los), .ber_q(ber), .slip_q(slip), .yel_q(ryel), .done_q(done), .pass_q(pass));

  lcai_ctrl #(.FLASH_HALF(FLASH_SIM)) dut_u (.clock(clock), .rst_b(rst_b), .selftest_done(done),
    .selftest_pass(pass), .rx_loss_of_signal(los), .rx_bit_err_exceeded(ber),
    .rx_slip_exceeded(slip), .rx_yellow_alarm(ryel), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(rdata),
    .card_state_lamp_q(card), .near_end_alarm_lamp_q(near), .far_end_alarm_lamp_q(far),
    .service_mode_lamp_q(svc), .tx_yellow_alarm_q(txy), .irq_q(irq));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      bad_count++;
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    d = rdata;
  endtask : rd

  task automatic do_reset;
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
  endtask : do_reset

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] d;
    cyc(1);
    chk("lamps", {card, near, far, svc, txy, irq}, 8'h20);
    rd(ADDR_CTRL, d);
    chk("ctrl", d, CTRL_RESET);
    rd(4'hF, d);
    chk("unmapped", d, 8'h00);
  endtask : t_reset

  task automatic t_red;
    logic [7:0] d;
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      cause <= 3'h1 << i;
      cyc(4);
      chk("near on", near, 1'b1);
      chk("tx yel on", txy, 1'b1);
      rd(ADDR_STATUS, d);
      chk("status red", d, 8'h13);
      cause <= 3'h0;
      cyc(4);
      chk("near off", {near, txy}, 2'b00);
    end
  endtask : t_red

  task automatic t_latch;
    wr(ADDR_CTRL, 8'h00);
    cause <= 3'h2;
    cyc(4);
    cause <= 3'h0;
    cyc(6);
    chk("near held", near, 1'b1);
    chk("tx yel free", txy, 1'b0);
    wr(ADDR_CMD, 8'h01);
    cyc(3);
    chk("near released", near, 1'b0);
    wr(ADDR_CTRL, CTRL_RESET);
  endtask : t_latch

  task automatic t_far;
    @(posedge clock);
    far_end_alarm_lamp <= 1'b1;
    cyc(4);
    chk("far on", far, 1'b1);
    far_end_alarm_lamp <= 1'b0;
    cyc(4);
    chk("far off", far, 1'b0);
  endtask : t_far

  task automatic t_svc;
    for (int v = 1; v < 4; v++) begin
      wr(ADDR_CTRL, CTRL_RESET | 8'(v << 4));
      cyc(3);
      chk("svc on", svc, 1'b1);
      wr(ADDR_CTRL, CTRL_RESET);
      cyc(3);
      chk("svc off", svc, 1'b0);
    end
  endtask : t_svc

  task automatic t_irq;
    logic [7:0] d;
    wr(ADDR_IRQ_STAT, 8'h0F);
    wr(ADDR_IRQ_MASK, 8'h01);
    cause <= 3'h4;
    cyc(5);
    chk("irq red", irq, 1'b1);
    rd(ADDR_IRQ_STAT, d);
    chk("irq stat rise", d, 8'h01);
    wr(ADDR_IRQ_MASK, 8'h00);
    cyc(3);
    chk("irq masked", irq, 1'b0);
    wr(ADDR_IRQ_MASK, 8'h03);
    wr(ADDR_IRQ_STAT, 8'h01);
    cyc(3);
    chk("irq cleared", irq, 1'b0);
    cause <= 3'h0;
    cyc(5);
    chk("irq fall", irq, 1'b1);
    wr(ADDR_IRQ_STAT, 8'h02);
    cyc(3);
    chk("irq idle", irq, 1'b0);
  endtask : t_irq

  task automatic t_fail;
    logic [7:0] d;
    wr(ADDR_CTRL, 8'h0F);
    ok <= 1'b0;
    fin <= 1'b1;
    cyc(20);
    chk("card failed", card, 1'b1);
    rd(ADDR_STATUS, d);
    chk("status failed", d, 8'h41);
    fin <= 1'b0;
    do_reset();
    cyc(3);
    chk("card after reset", card, 1'b1);
  endtask : t_fail

  task automatic t_pass;
    int n;
    int falls;
    logic last;
    ok <= 1'b1;
    fin <= 1'b1;
    cyc(2);
    chk("card testing", card, 1'b1);
    n = 0;
    while (card !== 1'b0) begin
      if (n++ > 10) begin
        bad_count++;
        conclude();
      end
      cyc(1);
    end
    cyc(FLASH_SIM / 2);
    chk("first flash dark", card, 1'b0);
    falls = 1;
    last = 1'b0;
    repeat (7 * FLASH_SIM) begin
      cyc(1);
      if (last === 1'b1 && card === 1'b0) falls++;
      last = card;
    end
    chk("flash count", 8'(falls), 8'(FLASH_COUNT));
    chk("steady lit", card, 1'b1);
  endtask : t_pass

  task automatic t_slots;
    logic [7:0] d;
    chk("unconfigured lit", card, 1'b1);
    rd(ADDR_IRQ_STAT, d);
    chk("selftest irq", d, 8'h01 << IRQ_ST_DONE);
    wr(ADDR_CTRL, CTRL_RESET | 8'h01);
    cyc(2);
    chk("no slot lit", card, 1'b1);
    wr(ADDR_CTRL, CTRL_RESET | 8'h03);
    cyc(2);
    chk("slot0 dark", card, 1'b0);
    wr(ADDR_CTRL, CTRL_RESET | 8'h07);
    cyc(2);
    chk("both dark", card, 1'b0);
    wr(ADDR_CTRL, CTRL_RESET | 8'h05);
    cyc(2);
    chk("one off dark", card, 1'b0);
    rd(ADDR_STATUS, d);
    chk("status active", d, 8'hA0);
    wr(ADDR_CTRL, CTRL_RESET | 8'h01);
    cyc(2);
    chk("both off lit", card, 1'b1);
    wr(ADDR_CTRL, CTRL_RESET);
  endtask : t_slots

  initial begin
    do_reset();
    t_reset();
    t_red();
    t_latch();
    t_far();
    t_svc();
    t_irq();
    t_fail();
    t_pass();
    t_slots();
    conclude();
  end
endmodule : tb_line_card_alarm_indicator_ctrl
